/* logic/abm_pkg.sv */
// Shared constants for the autobaud, error and reset block.
package abm_pkg;

	// ----------------------------------------------------------------
	// Register indices on the plain register port
	// ----------------------------------------------------------------
	localparam logic [2:0] WR_TX_DATA  = 3'h0; // Transmit data.
	localparam logic [2:0] WR_TEST     = 3'h2; // Test register, bit 0 is test A.
	localparam logic [2:0] WR_CONTROL  = 3'h4; // Control register.
	localparam logic [2:0] WR_INT_PROG = 3'h5; // Interrupt programming.
	localparam logic [2:0] WR_DIV_LO   = 3'h6; // Divisor low byte.
	localparam logic [2:0] WR_DIV_HI   = 3'h7; // Divisor high byte.
	localparam logic [2:0] RD_RX_DATA  = 3'h0; // Receive data.
	localparam logic [2:0] RD_STATUS   = 3'h1; // Status bits.
	localparam logic [2:0] RD_TEST     = 3'h2; // Test register readback.
	localparam logic [2:0] RD_DIV_LO   = 3'h3; // Divisor low byte.
	localparam logic [2:0] RD_DIV_HI   = 3'h4; // Divisor high byte.

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int TEST_A_BIT      = 0; // Test A select in the test register.
	localparam int SPEED_MATCH_BIT = 3; // Speed match request, also test B.
	localparam int TX_RESET_BIT    = 5; // Holds the transmitter idle.
	localparam int INT_SEL_LSB     = 3; // Interrupt select field low bit.
	localparam int ST_RX_FULL      = 0; // Status: receive data waiting.
	localparam int ST_BREAK        = 1; // Status: break seen while matching.
	localparam int ST_MATCHED      = 2; // Status: a divisor was measured.
	localparam int ST_TX_BUSY      = 3; // Status: transmitter shifting.

	// ----------------------------------------------------------------
	// Values after reset and selector codes
	// ----------------------------------------------------------------
	localparam logic [7:0]  CONTROL_RESET  = 8'h00;
	localparam logic [7:0]  INT_PROG_RESET = 8'h38;
	localparam logic [7:0]  TEST_RESET     = 8'h00;
	localparam logic [15:0] DIVISOR_RESET  = 16'h0010;
	localparam logic [2:0]  INT_SEL_MATCH  = 3'h0;

	// ----------------------------------------------------------------
	// Counts in system clock periods, ticks and bits
	// ----------------------------------------------------------------
	localparam logic [15:0] SHORT_PULSE = 16'h0048; // 72 periods.
	localparam logic [15:0] VALID_MAX   = 16'h8007; // 32775 periods.
	localparam logic [15:0] BREAK_LIMIT = 16'h8008; // 32776 periods.
	localparam int          OVERSAMPLE  = 4;        // Divisor is pulse over 16.
	localparam logic [3:0]  HALF_BIT    = 4'h7;     // Start bit midpoint tick.
	localparam logic [3:0]  LAST_PHASE  = 4'hF;     // Last tick of a bit.
	localparam logic [3:0]  MATCH_PHASE = 4'h8;     // Phase after a matched start.
	localparam logic [3:0]  FRAME_BITS  = 4'h9;     // Eight data bits plus stop.

endpackage : abm_pkg

/* logic/abm_pulse_meter.sv */
// Measures the first low pulse on the receive line during speed matching.
`timescale 1ns/1ps
module abm_pulse_meter (
	input  wire logic        clock_in,
	input  wire logic        rst_n_in,
	input  wire logic        arm_in,
	input  wire logic        fall_in,
	input  wire logic        rise_in,
	input  wire logic        low_in,
	output logic             start_out,
	output logic             done_out,
	output logic             break_out,
	output logic [15:0]      divisor_out
);

	// ----------------------------------------------------------------
	// Counter state
	// ----------------------------------------------------------------
	logic        active_q, active_d;    // Pulse is being timed.
	logic [15:0] count_q, count_d;      // Periods the line has been low.
	logic        start_q, start_d;      // Pulse: first falling edge seen.
	logic        done_q, done_d;        // Pulse: divisor loaded.
	logic        brk_q, brk_d;          // Pulse: pulse ran past break limit.
	logic [15:0] div_q, div_d;          // Divisor estimate.

	// The counter starts on the falling edge, advances each period and stops on the rise.
	always_comb begin
		active_d = active_q;
		count_d  = count_q;
		start_d  = 1'b0;
		done_d   = 1'b0;
		brk_d    = 1'b0;
		div_d    = div_q;
		if (!active_q) begin
			if (arm_in && fall_in) begin
				active_d = 1'b1;
				count_d  = 16'h0001;
				start_d  = 1'b1;
			end
		end else if (rise_in) begin
			// Short pulses fall out naturally as a divisor of four or less, or zero.
			active_d = 1'b0;
			done_d   = 1'b1;
			div_d    = count_q >> abm_pkg::OVERSAMPLE;
		end else if (low_in) begin
			if (count_q == abm_pkg::BREAK_LIMIT) begin
				// A break loads nothing and gives no end-of-pulse event.
				active_d = 1'b0;
				brk_d    = 1'b1;
			end else begin
				count_d = count_q + 16'h0001;
			end
		end
	end

	// Register the meter state.
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			active_q <= 1'b0;
			count_q  <= 16'h0000;
			start_q  <= 1'b0;
			done_q   <= 1'b0;
			brk_q    <= 1'b0;
			div_q    <= 16'h0000;
		end else begin
			active_q <= active_d;
			count_q  <= count_d;
			start_q  <= start_d;
			done_q   <= done_d;
			brk_q    <= brk_d;
			div_q    <= div_d;
		end
	end

	assign start_out   = start_q;
	assign done_out    = done_q;
	assign break_out   = brk_q;
	assign divisor_out = div_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);

	a_short_load: assert property (active_q && rise_in && count_q < abm_pkg::SHORT_PULSE
		|=> done_q && div_q <= 16'h0004) else $error("short pulse gave usable divisor");
	a_valid_load: assert property (active_q && rise_in && count_q > abm_pkg::SHORT_PULSE
		|=> done_q && div_q == ($past(count_q) >> 4)) else $error("valid pulse not loaded");
	a_break_quiet: assert property (brk_q |-> !done_q && $stable(div_q))
		else $error("break loaded a divisor");

endmodule : abm_pulse_meter

/* logic/abm_baud_tick.sv */
// Divides the system clock by the divisor into oversampling tick pulses.
`timescale 1ns/1ps
module abm_baud_tick (
	input  wire logic        clock_in,
	input  wire logic        rst_n_in,
	input  wire logic        restart_in,
	input  wire logic [15:0] divisor_in,
	output logic             tick_out
);

	// ----------------------------------------------------------------
	// Divider
	// ----------------------------------------------------------------
	logic [15:0] cnt_q, cnt_d;   // Periods since the last tick.
	logic        tick_q, tick_d; // One-period tick.

	// A zero divisor never ticks, which halts both serial directions.
	always_comb begin
		cnt_d  = cnt_q + 16'h0001;
		tick_d = 1'b0;
		if (restart_in || divisor_in == 16'h0000) begin
			cnt_d = 16'h0000;
		end else if (cnt_q + 16'h0001 >= divisor_in) begin
			cnt_d  = 16'h0000;
			tick_d = 1'b1;
		end
	end

	// Register the divider.
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			cnt_q  <= 16'h0000;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick_out = tick_q;

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);

	a_zero_halts: assert property (divisor_in == 16'h0000 |=> !tick_q)
		else $error("tick with zero divisor");

endmodule : abm_baud_tick

/* logic/abm_autobaud.sv */
// Top of the autobaud block: registers, serial engines, pin enables.
`timescale 1ns/1ps

module abm_autobaud (
	input  wire logic       clock_in,
	input  wire logic       rst_n_in,
	input  wire logic [2:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	input  wire logic       rxd_in,
	output logic      [7:0] rdata_out,
	output logic            rdata_oe_out,
	output logic            txd_out,
	output logic            txd_oe_out,
	output logic            irq_out,
	output logic            irq_oe_out
);

	// ----------------------------------------------------------------
	// Types and declarations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} abm_rx_type;

	logic        sync1_q, sync2_q, sync3_q; // Receive line synchroniser and history.
	logic [7:0]  ctrl_q, ctrl_d;            // Control register.
	logic [7:0]  intp_q, intp_d;            // Interrupt programming.
	logic [7:0]  test_q, test_d;            // Test register.
	logic [15:0] div_q, div_d;              // Active divisor.
	logic [7:0]  rxbuf_q, rxbuf_d;          // Receive data register.
	logic [7:0]  txbuf_q, txbuf_d;          // Transmit data register.
	logic        rxfull_q, rxfull_d;        // Receive data waiting.
	logic        txpend_q, txpend_d;        // Transmit data waiting.
	logic        brk_q, brk_d;              // Break seen while matching.
	logic        match_q, match_d;          // Divisor was measured.
	logic        irq_q, irq_d;              // Latched match interrupt.
	logic [7:0]  rdata_q, rdata_d;          // Read data.
	logic        rdoe_q, rdoe_d;            // Read data drive enable.
	abm_rx_type  rx_q, rx_d;                // Receiver state.
	logic [3:0]  rxph_q, rxph_d;            // Receiver tick phase.
	logic [2:0]  rxbit_q, rxbit_d;          // Receiver bit index.
	logic [7:0]  rxsh_q, rxsh_d;            // Receiver shift register.
	logic [9:0]  txsh_q, txsh_d;            // Transmit frame, start first.
	logic [3:0]  txph_q, txph_d;            // Transmitter tick phase.
	logic [3:0]  txcnt_q, txcnt_d;          // Transmit bits left after this.
	logic        txbusy_q, txbusy_d;        // Transmitter shifting.
	logic        txd_q, txd_d;              // Transmit line.
	logic        fall, rise, low;           // Receive line events.
	logic        m_start, m_done, m_brk;    // Meter events.
	logic [15:0] m_div;                     // Meter estimate.
	logic        tick;                      // Oversampling tick.
	logic        wr_match_zero;             // Host writes a zero to the request.

	// ----------------------------------------------------------------
	// Receive line synchroniser
	// ----------------------------------------------------------------
	// Only the second and third stages are looked at; the first may be metastable.
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
			sync3_q <= 1'b1;
		end else begin
			sync1_q <= rxd_in;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	assign fall = sync3_q && !sync2_q;
	assign rise = !sync3_q && sync2_q;
	assign low  = !sync2_q;

	// ----------------------------------------------------------------
	// Measurement and tick generation
	// ----------------------------------------------------------------
	abm_pulse_meter u_meter (
		.clock_in    (clock_in),
		.rst_n_in    (rst_n_in),
		.arm_in      (ctrl_q[abm_pkg::SPEED_MATCH_BIT]),
		.fall_in     (fall),
		.rise_in     (rise),
		.low_in      (low),
		.start_out   (m_start),
		.done_out    (m_done),
		.break_out   (m_brk),
		.divisor_out (m_div)
	);

	abm_baud_tick u_tick (
		.clock_in   (clock_in),
		.rst_n_in   (rst_n_in),
		.restart_in (m_done),
		.divisor_in (div_q),
		.tick_out   (tick)
	);

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	assign wr_match_zero = wr_in && addr_in == abm_pkg::WR_CONTROL
		&& !wdata_in[abm_pkg::SPEED_MATCH_BIT];

	// Host writes, reads and the hardware events that set status bits.
	always_comb begin
		ctrl_d   = ctrl_q;
		intp_d   = intp_q;
		test_d   = test_q;
		div_d    = div_q;
		txbuf_d  = txbuf_q;
		txpend_d = txpend_q;
		rxfull_d = rxfull_q;
		brk_d    = brk_q;
		match_d  = match_q;
		irq_d    = irq_q;
		rdata_d  = 8'h00;
		rdoe_d   = rd_in;
		if (wr_in) begin
			case (addr_in)
				abm_pkg::WR_TX_DATA: begin
					txbuf_d  = wdata_in;
					txpend_d = 1'b1;
				end
				// Test A and test B are stored only; software must leave them clear.
				abm_pkg::WR_TEST:     test_d = wdata_in;
				abm_pkg::WR_CONTROL:  ctrl_d = wdata_in;
				abm_pkg::WR_INT_PROG: intp_d = wdata_in;
				abm_pkg::WR_DIV_LO:   div_d  = {div_q[15:8], wdata_in};
				abm_pkg::WR_DIV_HI:   div_d  = {wdata_in, div_q[7:0]};
				default: begin
				end
			endcase
		end
		// Writing a zero to the request bit drops the latched interrupt.
		if (wr_match_zero) begin
			irq_d = 1'b0;
		end
		if (rd_in) begin
			case (addr_in)
				abm_pkg::RD_RX_DATA: begin
					rdata_d  = rxbuf_q;
					rxfull_d = 1'b0;
				end
				abm_pkg::RD_STATUS: begin
					rdata_d = {4'h0, txbusy_q, match_q, brk_q, rxfull_q};
					brk_d   = 1'b0;
				end
				abm_pkg::RD_TEST:   rdata_d = test_q;
				abm_pkg::RD_DIV_LO: rdata_d = div_q[7:0];
				abm_pkg::RD_DIV_HI: rdata_d = div_q[15:8];
				default:            rdata_d = 8'h00;
			endcase
		end
		// Hardware events come last so that they beat a host write or read in the same cycle, except the transmitter take.
		if (m_start) begin
			ctrl_d[abm_pkg::SPEED_MATCH_BIT] = 1'b0;
		end
		if (m_done) begin
			div_d   = m_div;
			match_d = 1'b1;
			if (intp_q[abm_pkg::INT_SEL_LSB +: 3] == abm_pkg::INT_SEL_MATCH) begin
				irq_d = 1'b1;
			end
		end
		if (m_brk) begin
			brk_d = 1'b1;
		end
		if (rx_q == RX_DATA && tick && rxph_q == abm_pkg::LAST_PHASE && rxbit_q == 3'h7) begin
			rxfull_d = 1'b1;
		end
		// A byte written as the transmitter takes the last one stays pending.
		if (!txbusy_q && txpend_q && !ctrl_q[abm_pkg::TX_RESET_BIT]
			&& !(wr_in && addr_in == abm_pkg::WR_TX_DATA)) begin
			txpend_d = 1'b0;
		end
	end

	// Register the host-visible state; reset clears data and status, sets defaults.
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			ctrl_q   <= abm_pkg::CONTROL_RESET;
			intp_q   <= abm_pkg::INT_PROG_RESET;
			test_q   <= abm_pkg::TEST_RESET;
			div_q    <= abm_pkg::DIVISOR_RESET;
			txbuf_q  <= 8'h00;
			rxbuf_q  <= 8'h00;
			txpend_q <= 1'b0;
			rxfull_q <= 1'b0;
			brk_q    <= 1'b0;
			match_q  <= 1'b0;
			irq_q    <= 1'b0;
			rdata_q  <= 8'h00;
			rdoe_q   <= 1'b0;
		end else begin
			ctrl_q   <= ctrl_d;
			intp_q   <= intp_d;
			test_q   <= test_d;
			div_q    <= div_d;
			txbuf_q  <= txbuf_d;
			rxbuf_q  <= rxbuf_d;
			txpend_q <= txpend_d;
			rxfull_q <= rxfull_d;
			brk_q    <= brk_d;
			match_q  <= match_d;
			irq_q    <= irq_d;
			rdata_q  <= rdata_d;
			rdoe_q   <= rdoe_d;
		end
	end

	// ----------------------------------------------------------------
	// Receiver
	// ----------------------------------------------------------------
	// After a measurement the receiver picks up at data bit 0 with whatever divisor
	// was loaded, so a bad estimate corrupts the rest of that character.
	always_comb begin
		rx_d    = rx_q;
		rxph_d  = rxph_q;
		rxbit_d = rxbit_q;
		rxsh_d  = rxsh_q;
		rxbuf_d = rxbuf_q;
		case (rx_q)
			RX_IDLE: begin
				if (m_done) begin
					rx_d    = RX_DATA;
					rxph_d  = abm_pkg::MATCH_PHASE;
					rxbit_d = 3'h0;
				end else if (fall && !ctrl_q[abm_pkg::SPEED_MATCH_BIT]) begin
					rx_d   = RX_START;
					rxph_d = 4'h0;
				end
			end
			RX_START: begin
				if (tick) begin
					rxph_d = rxph_q + 4'h1;
					if (rxph_q == abm_pkg::HALF_BIT) begin
						rx_d    = low ? RX_DATA : RX_IDLE;
						rxph_d  = 4'h0;
						rxbit_d = 3'h0;
					end
				end
			end
			RX_DATA: begin
				if (tick) begin
					rxph_d = rxph_q + 4'h1;
					if (rxph_q == abm_pkg::LAST_PHASE) begin
						rxsh_d  = {sync2_q, rxsh_q[7:1]};
						rxbit_d = rxbit_q + 3'h1;
						if (rxbit_q == 3'h7) begin
							rxbuf_d = {sync2_q, rxsh_q[7:1]};
							rx_d    = RX_IDLE;
						end
					end
				end
			end
			default: rx_d = RX_IDLE;
		endcase
	end

	// Register the receiver.
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			rx_q    <= RX_IDLE;
			rxph_q  <= 4'h0;
			rxbit_q <= 3'h0;
			rxsh_q  <= 8'h00;
		end else begin
			rx_q    <= rx_d;
			rxph_q  <= rxph_d;
			rxbit_q <= rxbit_d;
			rxsh_q  <= rxsh_d;
		end
	end

	// ----------------------------------------------------------------
	// Transmitter
	// ----------------------------------------------------------------
	// Shifts start, eight data bits and stop, one bit per sixteen ticks.
	always_comb begin
		txsh_d   = txsh_q;
		txph_d   = txph_q;
		txcnt_d  = txcnt_q;
		txbusy_d = txbusy_q;
		txd_d    = txd_q;
		if (ctrl_q[abm_pkg::TX_RESET_BIT]) begin
			txbusy_d = 1'b0;
			txd_d    = 1'b1;
		end else if (!txbusy_q) begin
			if (txpend_q) begin
				txsh_d   = {1'b1, txbuf_q, 1'b0};
				txbusy_d = 1'b1;
				txph_d   = 4'h0;
				txcnt_d  = abm_pkg::FRAME_BITS;
				txd_d    = 1'b0;
			end
		end else if (tick) begin
			txph_d = txph_q + 4'h1;
			if (txph_q == abm_pkg::LAST_PHASE) begin
				txsh_d = {1'b1, txsh_q[9:1]};
				txd_d  = txsh_q[1];
				if (txcnt_q == 4'h0) begin
					txbusy_d = 1'b0;
					txd_d    = 1'b1;
				end else begin
					txcnt_d = txcnt_q - 4'h1;
				end
			end
		end
	end

	// Register the transmitter.
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			txsh_q   <= 10'h3FF;
			txph_q   <= 4'h0;
			txcnt_q  <= 4'h0;
			txbusy_q <= 1'b0;
			txd_q    <= 1'b1;
		end else begin
			txsh_q   <= txsh_d;
			txph_q   <= txph_d;
			txcnt_q  <= txcnt_d;
			txbusy_q <= txbusy_d;
			txd_q    <= txd_d;
		end
	end

	// ----------------------------------------------------------------
	// Pin drive enables
	// ----------------------------------------------------------------
	logic txoe_q;  // Transmit pin enable, low in reset.
	logic irqoe_q; // Interrupt pin enable, low in reset.

	// Every enable drops while reset is held so the pins can be back-driven.
	always_ff @(posedge clock_in) begin
		txoe_q  <= rst_n_in;
		irqoe_q <= rst_n_in;
	end

	assign rdata_out    = rdata_q;
	assign rdata_oe_out = rdoe_q;
	assign txd_out      = txd_q;
	assign txd_oe_out   = txoe_q;
	assign irq_out      = irq_q;
	assign irq_oe_out   = irqoe_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_reset_float: assert property (@(posedge clock_in) !rst_n_in
		|=> !txoe_q && !irqoe_q && !rdoe_q) else $error("pin driven during reset");
	a_reset_bus_in: assert property (@(posedge clock_in) !rst_n_in ##1 !rst_n_in
		|-> !rdoe_q && rdata_q == 8'h00) else $error("data bus driven during reset");
	a_reset_clear: assert property (@(posedge clock_in) !rst_n_in
		|=> !rxfull_q && !brk_q && !match_q && rxbuf_q == 8'h00) else $error("status kept");
	a_reset_ctrl: assert property (@(posedge clock_in) !rst_n_in
		|=> ctrl_q == abm_pkg::CONTROL_RESET && intp_q == abm_pkg::INT_PROG_RESET)
		else $error("control not defaulted");
	a_req_clear: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		m_start |=> !ctrl_q[abm_pkg::SPEED_MATCH_BIT]) else $error("request not cleared");

	sequence s_matched_prog;
		m_done && intp_q[5:3] == 3'h0;
	endsequence
	a_match_irq: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		s_matched_prog |=> irq_q) else $error("match interrupt missing");
	a_break_noirq: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		m_brk && !irq_q |=> !irq_q && brk_q) else $error("break raised interrupt");
	a_rx_follows: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		m_done && rx_q == RX_IDLE |=> rx_q == RX_DATA && rxph_q == 4'h8)
		else $error("receiver did not continue");

endmodule : abm_autobaud

/* verif/abm_serial_src.sv */
// Remote serial transmitter model that drives the receive line.
`timescale 1ns/1ps
module abm_serial_src (
	input  wire logic clock_in,
	output logic      rxd_out
);
	// The line rests high between characters, like an idle sender.
	initial rxd_out = 1'b1;

	// First low pulse of pulse_len cycles, then data LSB first, then idle.
	// Callers enter just after a rising edge so the line moves off the edge.
	task automatic send(input int pulse_len, input int bit_len, input logic [7:0] data_in);
		rxd_out <= 1'b0;
		repeat (pulse_len) @(posedge clock_in);
		for (int i = 0; i < 8; i++) begin
			rxd_out <= data_in[i];
			repeat (bit_len) @(posedge clock_in);
		end
		rxd_out <= 1'b1;
		repeat (bit_len) @(posedge clock_in);
	endtask : send
endmodule : abm_serial_src

/* verif/tb_abm_autobaud.sv */
// Self-checking bench for the autobaud, error and reset block.
`timescale 1ns/1ps
module tb_abm_autobaud;
	logic       clock_in = 1'b0;
	logic       rst_n_in = 1'b0;
	logic [2:0] addr_in  = 3'h0;
	logic [7:0] wdata_in = 8'h00;
	logic       wr_in    = 1'b0;
	logic       rd_in    = 1'b0;
	logic       rxd;
	logic [7:0] rdata_out;
	logic       rdata_oe_out;
	logic       txd_out;
	logic       txd_oe_out;
	logic       irq_out;
	logic       irq_oe_out;
	int         mismatches  = 0;
	int         comparisons = 0;

	always #5 clock_in = ~clock_in;

	abm_autobaud uut (.clock_in(clock_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rxd_in(rxd),
		.rdata_out(rdata_out), .rdata_oe_out(rdata_oe_out), .txd_out(txd_out),
		.txd_oe_out(txd_oe_out), .irq_out(irq_out), .irq_oe_out(irq_oe_out));
	abm_serial_src u_src (.clock_in(clock_in), .rxd_out(rxd));

	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	// Compares with case equality so an unknown never passes.
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// One-cycle write strobe.
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock_in);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge clock_in);
		wr_in <= 1'b0;
	endtask : wr

	// One-cycle read strobe; data are taken in the following cycle only.
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clock_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clock_in);
		rd_in <= 1'b0;
		#1;
		d = rdata_out;
		chk("read enable", 16'h1, {15'h0, rdata_oe_out});
	endtask : rd

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run

	// Break measurement alone needs about 33k cycles; allow generous margin.
	initial begin
		repeat (60000) @(posedge clock_in);
		mismatches++;
		complete_run();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin : main
		logic [7:0] v;
		logic [7:0] h;
		repeat (9) @(posedge clock_in);
		#1;
		chk("bus enable", 16'h0, {15'h0, rdata_oe_out});
		chk("txd enable", 16'h0, {15'h0, txd_oe_out});
		chk("irq enable", 16'h0, {15'h0, irq_oe_out});
		chk("txd idle", 16'h1, {15'h0, txd_out});
		@(posedge clock_in);
		rst_n_in <= 1'b1;
		repeat (2) @(posedge clock_in);
		rd(abm_pkg::RD_STATUS, v); chk("status", 16'h0, v);
		rd(abm_pkg::RD_RX_DATA, v); chk("rx data", 16'h0, v);
		rd(abm_pkg::RD_TEST, v); chk("test", abm_pkg::TEST_RESET, v);
		rd(abm_pkg::RD_DIV_LO, v); chk("div lo", abm_pkg::DIVISOR_RESET[7:0], v);
		rd(abm_pkg::RD_DIV_HI, v); chk("div hi", abm_pkg::DIVISOR_RESET[15:8], v);
		// Test mode A is stored, then switched back off by the host.
		wr(abm_pkg::WR_TEST, 8'h01);
		rd(abm_pkg::RD_TEST, v); chk("test a", 16'h1, v);
		wr(abm_pkg::WR_TEST, 8'h00);
		// Valid pulse of 320 cycles gives a divisor of 20.
		wr(abm_pkg::WR_INT_PROG, 8'h00);
		wr(abm_pkg::WR_CONTROL, 8'h28);
		u_src.send(320, 320, 8'h55);
		chk("irq", 16'h1, {15'h0, irq_out});
		rd(abm_pkg::RD_DIV_LO, v); chk("div lo", 16'h14, v);
		rd(abm_pkg::RD_STATUS, v); chk("status", 16'h5, v);
		rd(abm_pkg::RD_RX_DATA, v); chk("rx data", 16'h55, v);
		// Request was cleared: the next start bit is a plain character.
		u_src.send(320, 320, 8'hA3);
		rd(abm_pkg::RD_RX_DATA, v); chk("rx data", 16'hA3, v);
		rd(abm_pkg::RD_DIV_LO, v); chk("div kept", 16'h14, v);
		wr(abm_pkg::WR_CONTROL, 8'h20);
		repeat (2) @(posedge clock_in);
		chk("irq clear", 16'h0, {15'h0, irq_out});
		// Short pulse of 40 cycles loads an unusable divisor.
		wr(abm_pkg::WR_CONTROL, 8'h28);
		u_src.send(40, 40, 8'h55);
		chk("irq short", 16'h1, {15'h0, irq_out});
		rd(abm_pkg::RD_DIV_LO, v);
		rd(abm_pkg::RD_DIV_HI, h);
		chk("short div", 16'h1, {15'h0, ({h, v} <= 16'h4) || ({h, v} == 16'hFFFF)});
		rd(abm_pkg::RD_RX_DATA, v);
		chk("rx corrupt", 16'h1, {15'h0, v != 8'h55});
		wr(abm_pkg::WR_CONTROL, 8'h20);
		// Pulse of 8 cycles leaves divisor 0, so the receiver stalls.
		wr(abm_pkg::WR_CONTROL, 8'h28);
		u_src.send(8, 320, 8'h55);
		rd(abm_pkg::RD_DIV_LO, v); chk("zero div", 16'h0, v);
		rd(abm_pkg::RD_STATUS, v); chk("rx stalled", 16'h0, v[0]);
		// A zero divisor also freezes the transmitter inside its start bit.
		wr(abm_pkg::WR_CONTROL, 8'h00);
		wr(abm_pkg::WR_TX_DATA, 8'hA5);
		repeat (40) @(posedge clock_in);
		chk("txd stalled", 16'h0, {15'h0, txd_out});
		rd(abm_pkg::RD_STATUS, v); chk("tx stalled", 16'h1, {15'h0, v[3]});
		// Low longer than 32776 cycles is a break: no load, no interrupt.
		wr(abm_pkg::WR_DIV_LO, 8'h14);
		wr(abm_pkg::WR_DIV_HI, 8'h00);
		wr(abm_pkg::WR_CONTROL, 8'h20);
		wr(abm_pkg::WR_CONTROL, 8'h28);
		u_src.send(33000, 1, 8'hFF);
		chk("irq break", 16'h0, {15'h0, irq_out});
		rd(abm_pkg::RD_STATUS, v); chk("break", 16'h1, v[1]);
		rd(abm_pkg::RD_DIV_LO, v); chk("div break", 16'h14, v);
		// A reset in mid-run must clear the status that the scenarios above left set.
		@(posedge clock_in);
		rst_n_in <= 1'b0;
		repeat (2) @(posedge clock_in);
		#1;
		chk("txd enable", 16'h0, {15'h0, txd_oe_out});
		chk("bus enable", 16'h0, {15'h0, rdata_oe_out});
		@(posedge clock_in);
		rst_n_in <= 1'b1;
		repeat (2) @(posedge clock_in);
		rd(abm_pkg::RD_STATUS, v); chk("status reset", 16'h0, v);
		rd(abm_pkg::RD_DIV_LO, v); chk("div reset", abm_pkg::DIVISOR_RESET[7:0], v);
		chk("irq enable", 16'h1, {15'h0, irq_oe_out});
		complete_run();
	end
endmodule : tb_abm_autobaud
